/* rtl/irsc_pkg.sv */
// constants and types for the infrared transceiver serial control port
package irsc_pkg;
    // ---------------------------------------------------------------
    // frame format
    // ---------------------------------------------------------------
    localparam logic [2:0] ADDR_OWN = 3'h2;
    localparam logic [2:0] ADDR_BCAST = 3'h7;
    localparam logic [3:0] IDX_RESET = 4'hd;
    localparam logic [3:0] IDX_MODE = 4'h1;
    localparam logic [3:0] IDX_ESC = 4'hf;
    localparam logic [3:0] NUM_REGS = 4'h3;
    localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
    localparam logic [4:0] LAST_STOP_BIT = 5'h01;
    localparam logic [4:0] READ_SKIP = 5'h0c;
    localparam logic [4:0] READ_EXT_SKIP = 5'h14;
    localparam logic [4:0] LOW_RESET = 5'h1e;
    localparam logic [23:0] REG_DEFAULTS = 24'h000000;
    // ---------------------------------------------------------------
    // register bus map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_REGS = 8'h08;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ACK_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ---------------------------------------------------------------
    // frame states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SYNC0 = 3'b000,
        ST_SYNC1 = 3'b001,
        ST_HDR = 3'b010,
        ST_SEL = 3'b011,
        ST_STOPS = 3'b100,
        ST_DATA = 3'b101,
        ST_STOPW = 3'b110,
        ST_SKIP = 3'b111
    } irsc_state_type;
endpackage

/* rtl/irsc_ctrl.sv */
// serial control port slave of an infrared transceiver, with register bus
//
// How it works
// - three lines: serial clock, command line on tx pin, reply on rx pin
// - one-byte special, two-byte write, two- and three-byte read frames
// - writes come on clock and command lines; reply line may acknowledge
// - act only on transceiver address 010 or broadcast 111
// - header: sync 0 then 1, direction, four index bits, three address bits
// - one command bit sampled per serial clock rising edge
// - index, address and data all travel least significant bit first
// - only reset special command and basic register writes act
// - framing of every frame tracked, ignored ones included
// - reset special command returns all registers to defaults
// - other special codes take no register action
// - write: index and address byte, then data byte sets register
// - index 1111 is the extended escape, never a register
// - index 0001 holds receiver bandwidth mode, 00 slowest, 05 fastest
// - command line low 30 serial clocks: restart framing, defaults
// - invalid reads get no response, invalid writes no acknowledge
`timescale 1ns/1ps
module irsc_ctrl #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial link pins
    input wire logic sclk_pin,
    input wire logic shared_tx_command_pin,
    input wire logic rx_data_in,
    output logic reply_pin,
    // transceiver registers
    output logic [23:0] xcvr_regs,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic sclk_s1, sclk_s2, sclk_s3, cmd_s1, cmd_s2, rx_s1, rx_s2;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {cmd_s1, cmd_s2, rx_s1, rx_s2} <= 4'hf;
        end else begin
            sclk_s1 <= sclk_pin;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cmd_s1 <= shared_tx_command_pin;
            cmd_s2 <= cmd_s1;
            rx_s1 <= rx_data_in;
            rx_s2 <= rx_s1;
        end
    end
    logic rise, bit_s;
    assign rise = sclk_s2 & ~sclk_s3;
    assign bit_s = cmd_s2;

    // ---------------------------------------------------------------
    // frame decoder
    // ---------------------------------------------------------------
    irsc_pkg::irsc_state_type st_q, st_d;
    logic [4:0] cnt_q, cnt_d, low_q, low_d;
    logic [7:0] sh_q, sh_d, hdr_q, hdr_d, data_q, data_d, frames_q, frames_d;
    logic [23:0] regs_q, regs_d;
    logic ack_q, ack_d, reply_q, reply_d;
    logic [1:0] ctrl_q;
    logic addr_ok, commit, special_hit, low_hit;
    logic [3:0] idx;
    logic [4:0] skip_last;

    assign idx = hdr_q[4:1];
    assign addr_ok = (hdr_q[7:5] == irsc_pkg::ADDR_OWN) || (hdr_q[7:5] == irsc_pkg::ADDR_BCAST);
    // escape index is below no register
    assign skip_last = (idx == irsc_pkg::IDX_ESC) ? irsc_pkg::READ_EXT_SKIP - 5'h01
                                                  : irsc_pkg::READ_SKIP - 5'h01;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        hdr_d = hdr_q;
        data_d = data_q;
        low_d = low_q;
        ack_d = ack_q;
        regs_d = regs_q;
        frames_d = frames_q;
        commit = 1'b0;
        special_hit = 1'b0;
        low_hit = 1'b0;
        if (rise) begin
            ack_d = 1'b0;
            // lsb arrives first, shift toward bit 0
            sh_d = {bit_s, sh_q[7:1]};
            cnt_d = cnt_q + 5'h01;
            if (bit_s) begin
                low_d = 5'h00;
            end else if (low_q != irsc_pkg::LOW_RESET) begin
                low_d = low_q + 5'h01;
            end
            // every frame is walked to its end
            case (st_q)
                irsc_pkg::ST_SYNC0: begin
                    cnt_d = 5'h00;
                    if (!bit_s) begin
                        st_d = irsc_pkg::ST_SYNC1;
                    end
                end
                // second sync bit opens the header
                irsc_pkg::ST_SYNC1: begin
                    cnt_d = 5'h00;
                    if (bit_s) begin
                        st_d = irsc_pkg::ST_HDR;
                    end
                end
                irsc_pkg::ST_HDR: begin
                    if (cnt_q == irsc_pkg::LAST_BYTE_BIT) begin
                        hdr_d = sh_d;
                        cnt_d = 5'h00;
                        // direction picks write or read shape
                        st_d = sh_d[0] ? irsc_pkg::ST_SEL : irsc_pkg::ST_SKIP;
                    end
                end
                // marker 1 means data byte follows
                irsc_pkg::ST_SEL: begin
                    cnt_d = 5'h00;
                    st_d = bit_s ? irsc_pkg::ST_DATA : irsc_pkg::ST_STOPS;
                end
                irsc_pkg::ST_STOPS: begin
                    st_d = irsc_pkg::ST_SYNC0;
                    special_hit = !bit_s && ctrl_q[irsc_pkg::CTRL_EN_BIT] && addr_ok
                                  && (idx == irsc_pkg::IDX_RESET);
                end
                irsc_pkg::ST_DATA: begin
                    if (cnt_q == irsc_pkg::LAST_BYTE_BIT) begin
                        data_d = sh_d;
                        cnt_d = 5'h00;
                        st_d = irsc_pkg::ST_STOPW;
                    end
                end
                // a bad stop bit drops the frame
                irsc_pkg::ST_STOPW: begin
                    if (bit_s) begin
                        st_d = irsc_pkg::ST_SYNC0;
                    end else if (cnt_q == irsc_pkg::LAST_STOP_BIT) begin
                        st_d = irsc_pkg::ST_SYNC0;
                        commit = ctrl_q[irsc_pkg::CTRL_EN_BIT] && addr_ok
                                 && (idx < irsc_pkg::NUM_REGS);
                    end
                end
                // reads are followed but never answered
                irsc_pkg::ST_SKIP: begin
                    if (cnt_q == skip_last) begin
                        st_d = irsc_pkg::ST_SYNC0;
                    end
                end
                default: st_d = irsc_pkg::ST_SYNC0;
            endcase
            if (low_d == irsc_pkg::LOW_RESET && low_q != irsc_pkg::LOW_RESET) begin
                low_hit = 1'b1;
                st_d = irsc_pkg::ST_SYNC0;
                cnt_d = 5'h00;
            end
        end
        // reset command and long low restore defaults
        if (special_hit || low_hit) begin
            regs_d = irsc_pkg::REG_DEFAULTS;
        end else if (commit) begin
            // index selects the byte, mode is index 1
            regs_d[idx[1:0]*8 +: 8] = data_q;
            frames_d = frames_q + 8'h01;
            // broadcast writes stay silent to avoid collisions
            ack_d = ctrl_q[irsc_pkg::CTRL_ACK_BIT] && (hdr_q[7:5] == irsc_pkg::ADDR_OWN);
        end
        reply_d = ack_d | rx_s2;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= irsc_pkg::ST_SYNC0;
            cnt_q <= 5'h00;
            low_q <= 5'h00;
            sh_q <= 8'h00;
            hdr_q <= 8'h00;
            data_q <= 8'h00;
            frames_q <= 8'h00;
            regs_q <= irsc_pkg::REG_DEFAULTS;
            ack_q <= 1'b0;
            reply_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            low_q <= low_d;
            sh_q <= sh_d;
            hdr_q <= hdr_d;
            data_q <= data_d;
            frames_q <= frames_d;
            regs_q <= regs_d;
            ack_q <= ack_d;
            reply_q <= reply_d;
        end
    end
    assign reply_pin = reply_q;
    assign xcvr_regs = regs_q;

    // ---------------------------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------------------------
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[7:0] == irsc_pkg::OFF_CTRL) || (a[7:0] == irsc_pkg::OFF_STAT)
                 || (a[7:0] == irsc_pkg::OFF_REGS);
    endfunction

    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
    logic w_lane0_q, w_lane0_d;
    logic [1:0] ctrl_d, bresp_q, bresp_d, rresp_q, rresp_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_lane0_d = w_lane0_q;
        ctrl_d = ctrl_q;
        bresp_d = bresp_q;
        bvalid_d = bvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        rvalid_d = rvalid_q;
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = wdata;
            w_lane0_d = wstrb[0];
        end
        // status and register words are read only, writes ignored
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(aw_addr_q) ? irsc_pkg::RESP_OKAY : irsc_pkg::RESP_SLVERR;
            if (aw_addr_q[7:0] == irsc_pkg::OFF_CTRL && w_lane0_q) begin
                ctrl_d = w_data_q[1:0];
            end
        end
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = mapped(araddr) ? irsc_pkg::RESP_OKAY : irsc_pkg::RESP_SLVERR;
            case (araddr[7:0])
                irsc_pkg::OFF_CTRL: rdata_d = {30'h0, ctrl_q};
                irsc_pkg::OFF_STAT: rdata_d = {16'h0, frames_q, 3'h0, ack_q, 1'h0, st_q};
                irsc_pkg::OFF_REGS: rdata_d = {8'h00, regs_q};
                default: rdata_d = 32'h0;
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_lane0_q <= 1'b0;
            ctrl_q <= irsc_pkg::CTRL_RESET;
            bresp_q <= 2'h0;
            bvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_lane0_q <= w_lane0_d;
            ctrl_q <= ctrl_d;
            bresp_q <= bresp_d;
            bvalid_q <= bvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            rvalid_q <= rvalid_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end
    assign awready = awready_q;
    assign wready = wready_q;
    assign bresp = bresp_q;
    assign bvalid = bvalid_q;
    assign arready = arready_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign rvalid = rvalid_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_sync;
        rise && st_q == irsc_pkg::ST_SYNC1 && bit_s && !low_hit |=> st_q == irsc_pkg::ST_HDR;
    endproperty
    a_sync: assert property (p_sync) else $error("sync 0 1 did not open header");
    property p_onebit;
        !rise |=> $stable(cnt_q) && $stable(st_q) && $stable(regs_q);
    endproperty
    a_onebit: assert property (p_onebit) else $error("state moved without sclk rise");
    property p_lsb;
        rise && st_q == irsc_pkg::ST_HDR && cnt_q == 5'h07 |=> hdr_q[7] == $past(bit_s);
    endproperty
    a_lsb: assert property (p_lsb) else $error("last header bit not msb");
    property p_addr;
        rise && st_q == irsc_pkg::ST_STOPW && !addr_ok && !low_hit |=> $stable(regs_q);
    endproperty
    a_addr: assert property (p_addr) else $error("foreign address wrote register");
    property p_reset;
        special_hit |=> regs_q == irsc_pkg::REG_DEFAULTS ##1 st_q == irsc_pkg::ST_SYNC0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset command missed");
    property p_special;
        rise && st_q == irsc_pkg::ST_STOPS && idx != irsc_pkg::IDX_RESET && !low_hit
            |=> $stable(regs_q);
    endproperty
    a_special: assert property (p_special) else $error("other special code acted");
    property p_escape;
        rise && st_q == irsc_pkg::ST_STOPW && idx == irsc_pkg::IDX_ESC && !low_hit
            |=> $stable(regs_q);
    endproperty
    a_escape: assert property (p_escape) else $error("escape index wrote register");
    property p_mode;
        commit && idx == irsc_pkg::IDX_MODE |=> regs_q[15:8] == $past(data_q);
    endproperty
    a_mode: assert property (p_mode) else $error("mode register not written");
    property p_low;
        low_hit |=> st_q == irsc_pkg::ST_SYNC0 && regs_q == irsc_pkg::REG_DEFAULTS;
    endproperty
    a_low: assert property (p_low) else $error("long low did not restart");
    property p_read;
        rise && st_q == irsc_pkg::ST_HDR && cnt_q == 5'h07 && !sh_q[1] && !low_hit
            |=> st_q == irsc_pkg::ST_SKIP;
    endproperty
    a_read: assert property (p_read) else $error("read frame not tracked");
    property p_noack;
        $rose(ack_q) |-> $past(hdr_q[7:5]) == irsc_pkg::ADDR_OWN && $past(idx) < 4'h3;
    endproperty
    a_noack: assert property (p_noack) else $error("acknowledge for invalid write");
    property p_acklen;
        ack_q && rise |=> !ack_q && reply_q == $past(rx_s2);
    endproperty
    a_acklen: assert property (p_acklen) else $error("acknowledge outlived sclk");
    property p_partial;
        !commit && !special_hit && !low_hit |=> $stable(regs_q);
    endproperty
    a_partial: assert property (p_partial) else $error("register changed mid frame");

    c_reset: cover property (special_hit);
    c_mode: cover property (commit && idx == irsc_pkg::IDX_MODE);
    c_low: cover property (low_hit);
    c_read: cover property (st_q == irsc_pkg::ST_SKIP ##1 st_q == irsc_pkg::ST_SYNC0);
endmodule

/* test/irsc_host_model.sv */
// behavioural model of the interface controller driving the serial link
`timescale 1ns/1ps
module irsc_host_model (
    // serial link lines
    output logic sclk,
    output logic cmd_line
);
    // ---------------------------------------------------------------
    // idle levels
    // ---------------------------------------------------------------
    // clock and command line
    initial begin
        sclk = 1'b0;
        cmd_line = 1'b1;
    end

    // ---------------------------------------------------------------
    // bit and idle tasks
    // ---------------------------------------------------------------
    // one bit per rise, 800 ns period
    // odd offsets keep both link clock edges off the system clock edges
    task automatic send_bit(input logic b);
        #37;
        cmd_line = b;
        #400;
        sclk = 1'b1;
        #350;
        sclk = 1'b0;
        #13;
    endtask

    // clock stands still low between frames, command line back to idle
    task automatic idle();
        cmd_line = 1'b1;
    endtask
endmodule

/* test/irsc_ctrl_bench.sv */
// self-checking bench for the serial control port slave
`timescale 1ns/1ps
module irsc_ctrl_bench;
    logic mclk;
    logic rst_n;
    logic rx_data_in;
    logic sclk_pin;
    logic shared_tx_command_pin;
    logic reply_pin;
    logic [23:0] xcvr_regs;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp;
    logic [1:0] rresp;
    int mismatches;
    int comparisons;

    irsc_ctrl #(.ADDR_W(8)) u_irsc_ctrl (
        .mclk(mclk), .rst_n(rst_n), .sclk_pin(sclk_pin),
        .shared_tx_command_pin(shared_tx_command_pin), .rx_data_in(rx_data_in),
        .reply_pin(reply_pin), .xcvr_regs(xcvr_regs),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    irsc_host_model u_irsc_host_model (
        .sclk(sclk_pin),
        .cmd_line(shared_tx_command_pin)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // compare and verdict
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // register bus tasks
    // ---------------------------------------------------------------
    // handshakes are judged from values settled before the edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ah, wh, bh;
        logic [1:0] r;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bh = 1'b0;
        n = 0;
        while (!bh) begin
            @(negedge mclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            r = bresp;
            @(posedge mclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
            n++;
            if (n > 50) begin
                check(32'h0, 32'h1);
                give_verdict();
            end
        end
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        logic ah, rh;
        logic [1:0] r;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rh = 1'b0;
        n = 0;
        while (!rh) begin
            @(negedge mclk);
            ah = arvalid && arready;
            rh = rvalid && rready;
            r = rresp;
            d = rdata;
            @(posedge mclk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
            n++;
            if (n > 50) begin
                check(32'h0, 32'h1);
                give_verdict();
            end
        end
        check({30'h0, r}, {30'h0, er});
    endtask

    // ---------------------------------------------------------------
    // serial frame tasks
    // ---------------------------------------------------------------
    // bit 0 of the vector goes out first
    task automatic ser(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            u_irsc_host_model.send_bit(v[i]);
        end
        u_irsc_host_model.idle();
        repeat (6) @(posedge mclk);
    endtask

    // index and address byte, then data byte and stops
    task automatic wr(input logic [3:0] idx, input logic [2:0] ad, input logic [7:0] d);
        ser({11'h0, 2'b00, d, 1'b1, ad, idx, 1'b1, 2'b10}, 21);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        mismatches = 0;
        comparisons = 0;
        rst_n = 1'b0;
        rx_data_in = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check({8'h0, xcvr_regs}, 32'h0);
        axi_read(irsc_pkg::OFF_CTRL, irsc_pkg::RESP_OKAY, rd);
        check(rd, 32'h1);
        axi_read(8'h0c, irsc_pkg::RESP_SLVERR, rd);
        check(rd, 32'h0);
        axi_write(8'h10, 32'h0, irsc_pkg::RESP_SLVERR);
        axi_write(irsc_pkg::OFF_CTRL, 32'h3, irsc_pkg::RESP_OKAY);
        // reply line also carries received data
        @(posedge mclk);
        rx_data_in <= 1'b1;
        repeat (5) @(posedge mclk);
        check({31'h0, reply_pin}, 32'h1);
        rx_data_in <= 1'b0;
        repeat (5) @(posedge mclk);
        check({31'h0, reply_pin}, 32'h0);
        wr(irsc_pkg::IDX_MODE, irsc_pkg::ADDR_OWN, 8'h05);
        check({8'h0, xcvr_regs}, 32'h000500);
        check({31'h0, reply_pin}, 32'h1);
        wr(irsc_pkg::IDX_MODE, irsc_pkg::ADDR_OWN, 8'h00);
        check({8'h0, xcvr_regs}, 32'h000000);
        wr(4'h0, irsc_pkg::ADDR_OWN, 8'h0f);
        check({8'h0, xcvr_regs}, 32'h00000f);
        wr(4'h2, irsc_pkg::ADDR_BCAST, 8'ha5);
        check({8'h0, xcvr_regs}, 32'ha5000f);
        check({31'h0, reply_pin}, 32'h0);
        wr(4'h0, 3'h1, 8'h33);
        check({8'h0, xcvr_regs}, 32'ha5000f);
        wr(irsc_pkg::IDX_ESC, irsc_pkg::ADDR_OWN, 8'h77);
        check({8'h0, xcvr_regs}, 32'ha5000f);
        check({31'h0, reply_pin}, 32'h0);
        // reads are framed but never answered, broadcast ones included
        ser({10'h0, 12'hffe, irsc_pkg::ADDR_OWN, irsc_pkg::IDX_MODE, 1'b0, 2'b10}, 22);
        check({31'h0, reply_pin}, 32'h0);
        ser({10'h0, 12'hffe, irsc_pkg::ADDR_BCAST, irsc_pkg::IDX_MODE, 1'b0, 2'b10}, 22);
        check({31'h0, reply_pin}, 32'h0);
        wr(irsc_pkg::IDX_MODE, irsc_pkg::ADDR_OWN, 8'h02);
        check({8'h0, xcvr_regs}, 32'ha5020f);
        check({31'h0, reply_pin}, 32'h1);
        // first stop bit high: whole frame must be dropped
        ser({11'h0, 2'b01, 8'h44, 1'b1, irsc_pkg::ADDR_OWN, 4'h0, 1'b1, 2'b10}, 21);
        check({8'h0, xcvr_regs}, 32'ha5020f);
        for (int c = 0; c < 15; c++) begin
            if (c != 13) begin
                ser({20'h0, 2'b00, irsc_pkg::ADDR_OWN, 4'(c), 1'b1, 2'b10}, 12);
                check({8'h0, xcvr_regs}, 32'ha5020f);
            end
        end
        ser({20'h0, 2'b00, 3'h4, irsc_pkg::IDX_RESET, 1'b1, 2'b10}, 12);
        check({8'h0, xcvr_regs}, 32'ha5020f);
        ser({20'h0, 2'b00, irsc_pkg::ADDR_OWN, irsc_pkg::IDX_RESET, 1'b1, 2'b10}, 12);
        check({8'h0, xcvr_regs}, 32'h000000);
        wr(4'h2, irsc_pkg::ADDR_OWN, 8'h5a);
        check({8'h0, xcvr_regs}, 32'h5a0000);
        // a high bit breaks the run of lows, so 29 must not reset
        ser(32'h1, 1);
        ser(32'h0, 29);
        check({8'h0, xcvr_regs}, 32'h5a0000);
        ser(32'h0, 1);
        check({8'h0, xcvr_regs}, 32'h000000);
        wr(irsc_pkg::IDX_MODE, irsc_pkg::ADDR_OWN, 8'h05);
        check({8'h0, xcvr_regs}, 32'h000500);
        // seven committed writes, acknowledge standing, hunting sync
        axi_read(irsc_pkg::OFF_STAT, irsc_pkg::RESP_OKAY, rd);
        check(rd, 32'h00000710);
        axi_read(irsc_pkg::OFF_REGS, irsc_pkg::RESP_OKAY, rd);
        check(rd, 32'h00000500);
        give_verdict();
    end
endmodule
